/* hdl/dsj_pkg.sv */
package dsj_pkg;
    localparam int unsigned ENV_PER_SEC    = 8000;
    localparam int unsigned NOM_BITS       = 5592;
    localparam int unsigned FIXED_BITS     = 5589;
    localparam int unsigned ROWS           = 9;
    localparam int unsigned CTRL_BITS      = 5;
    localparam int unsigned OPP_NOM        = 3;
    localparam int unsigned OPP_NEG        = 4;
    localparam int unsigned OPP_POS        = 2;
    localparam int unsigned FIX_PER_ROW    = 621;
    localparam int unsigned FILL_W         = 6;
    localparam logic [5:0]  FILL_CENTER    = 6'h20;
    localparam logic [5:0]  FILL_HI        = 6'h24;
    localparam logic [5:0]  FILL_LO        = 6'h1C;
    localparam logic [5:0]  FILL_MAX       = 6'h3F;
    localparam logic [3:0]  ROW_LAST       = 4'h8;
    localparam logic [9:0]  FIX_LAST       = 10'h26C;
    localparam logic [4:0]  CTRL_ONES      = 5'h1F;
    localparam logic [4:0]  CTRL_ZERO      = 5'h00;

    typedef enum logic [2:0] {
        DSJ_NOM = 3'h1,
        DSJ_NEG = 3'h2,
        DSJ_POS = 3'h4
    } dsj_just_t;

    // One slot request from the framing logic
    typedef struct packed {
        logic       env_start;  // first slot of an envelope
        logic       row_start;  // first slot of a row
        logic       fix_slot;   // fixed data position
        logic       ctl_slot;   // control bit position
        logic       opp_slot;   // stuff opportunity position
    } dsj_slot_t;

    // Bit produced toward the envelope
    typedef struct packed {
        logic       valid;
        logic       bit_val;
        logic       is_data;
    } dsj_out_t;
endpackage

/* hdl/dsj_justifier.sv */
`timescale 1ns/10ps
module dsj_justifier #(
    parameter int unsigned DEPTH = 64   // tributary elastic store depth
) (
    input  wire logic              sys_clk_i,  // 25 MHz system clock
    input  wire logic              srst_i,     // Sync reset, active high
    input  wire logic              trib_vld_i, // Tributary bit strobe
    input  wire logic              trib_bit_i, // Tributary data bit
    input  wire dsj_pkg::dsj_slot_t slot_i,    // Envelope slot strobe
    output logic                   env_bit_o,  // Envelope bit out
    output logic                   env_vld_o,  // Envelope bit valid
    output logic                   env_dat_o,  // Slot carried data
    output logic [3:0]             opp_cnt_o,  // Data opps last envelope
    output logic                   ovf_o,      // Store over/underrun seen
    output logic [5:0]             fill_o      // Store fill level
);
    import dsj_pkg::*;

    // Pointers are FILL_W bits wide, so only one store depth fits them
    if (DEPTH != 2 ** FILL_W) begin : g_depth_chk
        $error("DEPTH must equal the fill pointer range");
    end

    // Elastic store absorbs rate offset between tributary and payload
    logic [DEPTH-1:0] mem, next_mem;
    logic [5:0]       wr_p, rd_p, fill, next_wr_p, next_rd_p, next_fill;
    // Envelope sequencing state
    dsj_just_t        just, next_just;
    logic [3:0]       row, next_row;
    logic [3:0]       opp_used, next_opp_used;
    logic [3:0]       opp_ok, next_opp_ok;
    logic             row_data, next_row_data;
    logic             ovf, next_ovf;
    dsj_out_t         out_q, next_out;
    logic             pop;
    logic [3:0]       target;

    // Count of data opportunities, from the decision being taken now so
    // that row zero of a new envelope already follows it
    always_comb begin
        case (next_just)
            DSJ_NEG: target = 4'(OPP_NEG);
            DSJ_POS: target = 4'(OPP_POS);
            DSJ_NOM: target = 4'(OPP_NOM);
            default: target = 4'(OPP_NOM);
        endcase
    end

    // Slot handling and store bookkeeping
    always_comb begin
        next_mem      = mem;
        next_wr_p     = wr_p;
        next_rd_p     = rd_p;
        next_just     = just;
        next_row      = row;
        next_opp_used = opp_used;
        next_opp_ok   = opp_ok;
        next_row_data = row_data;
        next_ovf      = ovf;
        next_out      = '0;
        pop           = 1'b0;
        if (slot_i.env_start) begin
            // Decide once per envelope so the whole SPE is consistent
            next_opp_ok   = opp_used;
            next_opp_used = '0;
            next_row      = '0;
            if (fill > FILL_HI)
                next_just = DSJ_NEG;
            else if (fill < FILL_LO)
                next_just = DSJ_POS;
            else
                next_just = DSJ_NOM;
        end else if (slot_i.row_start && row != ROW_LAST) begin
            next_row = row + 4'h1;
        end
        // Front-load data opportunities in early rows; the first control
        // slot comes with row_start, so it must see the new decision
        if (slot_i.row_start)
            next_row_data = next_opp_used < target;
        if (slot_i.ctl_slot) begin
            next_out.valid   = 1'b1;
            next_out.bit_val = ~next_row_data;
        end else if (slot_i.fix_slot) begin
            pop = 1'b1;
        end else if (slot_i.opp_slot) begin
            if (next_row_data) begin
                pop           = 1'b1;
                next_opp_used = opp_used + 4'h1;
            end else begin
                next_out.valid = 1'b1;           // stuff bit, zero
            end
        end
        if (pop) begin
            next_out.valid   = 1'b1;
            next_out.is_data = 1'b1;
            next_out.bit_val = mem[rd_p];
            if (fill == '0)
                next_ovf = 1'b1;                 // underrun, bit repeated
            else
                next_rd_p = rd_p + 6'h01;
        end
        if (trib_vld_i) begin
            if (fill == FILL_MAX && !pop) begin
                next_ovf = 1'b1;                 // overrun, bit dropped
            end else begin
                next_mem[wr_p] = trib_bit_i;
                next_wr_p      = wr_p + 6'h01;
            end
        end
        next_fill = next_wr_p - next_rd_p;
    end

    // Register stage
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mem      <= '0;
            wr_p     <= FILL_CENTER;   // start half full for margin
            rd_p     <= '0;
            fill     <= FILL_CENTER;
            just     <= DSJ_NOM;
            row      <= '0;
            opp_used <= '0;
            opp_ok   <= '0;
            row_data <= 1'b0;
            ovf      <= 1'b0;
            out_q    <= '0;
        end else begin
            mem      <= next_mem;
            wr_p     <= next_wr_p;
            rd_p     <= next_rd_p;
            fill     <= next_fill;
            just     <= next_just;
            row      <= next_row;
            opp_used <= next_opp_used;
            opp_ok   <= next_opp_ok;
            row_data <= next_row_data;
            ovf      <= next_ovf;
            out_q    <= next_out;
        end
    end

    assign env_bit_o = out_q.bit_val;
    assign env_vld_o = out_q.valid;
    assign env_dat_o = out_q.is_data;
    assign opp_cnt_o = opp_ok;
    assign ovf_o     = ovf;
    assign fill_o    = fill;

    // Controls in a data row read zero; row_data holds the row afterwards
    a_ctrl_zero_data: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        slot_i.ctl_slot |=> !row_data || (env_vld_o && !env_bit_o))
        else $error("control bit not zero for data row");

    // Controls in a stuff row read one
    a_ctrl_one_stuff: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        slot_i.ctl_slot |=> row_data || (env_vld_o && env_bit_o))
        else $error("control bit not one for stuff row");

    // Fixed positions always carry tributary data
    a_fixed_is_data: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        slot_i.fix_slot && !slot_i.ctl_slot |=> env_dat_o)
        else $error("fixed slot did not carry data");

    // Never more data opportunities than a negative stuff allows
    a_opp_bounded: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        opp_used <= 4'(OPP_NEG))
        else $error("too many data opportunities");

    // High fill asks for a negative stuff
    a_neg_on_high: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        slot_i.env_start && fill > FILL_HI |=> just == DSJ_NEG)
        else $error("negative stuff not chosen");

    // Low fill asks for a positive stuff
    a_pos_on_low: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        slot_i.env_start && fill < FILL_LO |=> just == DSJ_POS)
        else $error("positive stuff not chosen");

    // Mid-band fill keeps the nominal count
    a_nom_mid: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        slot_i.env_start && fill >= FILL_LO && fill <= FILL_HI
        |=> just == DSJ_NOM)
        else $error("nominal not chosen");

    // Row index stays inside the nine rows
    a_row_bound: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        row <= ROW_LAST)
        else $error("row index beyond nine rows");

    // Stuff opportunities go out as a zero that is not data
    a_stuff_opp_zero: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        slot_i.opp_slot && !row_data |=> env_vld_o && !env_dat_o && !env_bit_o)
        else $error("stuff opportunity not sent as stuff");

    // Data opportunities carry a tributary bit
    a_data_opp_carried: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        slot_i.opp_slot && row_data |=> env_vld_o && env_dat_o)
        else $error("data opportunity did not carry data");

    // Each envelope restarts the row walk and the opportunity count
    a_env_restart: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        slot_i.env_start |=> row == '0 && opp_used == '0)
        else $error("envelope start did not restart rows");

    // A bit arriving at a full store with no read is flagged
    a_ovf_on_full: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        trib_vld_i && fill == FILL_MAX && !slot_i.fix_slot
        && !slot_i.opp_slot |=> ovf_o)
        else $error("overrun not flagged");

    // The loss flag holds until reset so software never misses it
    a_ovf_sticky: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        ovf_o |=> ovf_o)
        else $error("loss flag cleared without reset");
endmodule

/* verification/dsj_framer_model.sv */
`timescale 1ns/10ps
// Framing side: walks one envelope of nine rows per request
module dsj_framer_model (
    input  wire logic          sys_clk_i,  // System clock
    input  wire logic          srst_i,     // Sync reset
    input  wire logic          go_i,       // Start one envelope
    output dsj_pkg::dsj_slot_t slot_o,     // Slot strobes
    output logic [3:0]         slot_row_o, // Row of slot_o
    output logic               busy_o      // Envelope running
);
    import dsj_pkg::*;
    logic [9:0] pos;
    logic [3:0] row;
    logic       row_end;
    dsj_slot_t  nxt;
    // Row: 5 control, 1 opportunity, 621 fixed; back to back slots
    assign row_end = (pos == FIX_LAST + 10'h6);
    always_comb begin
        nxt           = '0;
        nxt.env_start = (pos == 10'h0) && (row == 4'h0);
        nxt.row_start = (pos == 10'h0);
        nxt.ctl_slot  = (pos < 10'h5);
        nxt.opp_slot  = (pos == 10'h5);
        nxt.fix_slot  = (pos > 10'h5);
    end
    // One assignment per signal and edge; idle slots are all low
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !(go_i || busy_o)) begin
            slot_o <= '0;
            busy_o <= 1'b0;
            pos    <= '0;
            row    <= '0;
        end else begin
            slot_o     <= nxt;
            slot_row_o <= row;
            busy_o     <= !(row_end && row == ROW_LAST);
            pos        <= row_end ? 10'h0 : pos + 10'h1;
            row        <= row_end ? row + 4'h1 : row;
        end
    end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import dsj_pkg::*;
    logic sys_clk_i = 1'b0, srst_i = 1'b1, trib_vld_i = 1'b0;
    logic trib_bit_i = 1'b0, go = 1'b0, busy, env_bit, env_vld, env_dat;
    logic ovf;
    logic [3:0] opp_cnt, srow, prow;
    logic [5:0] fill;
    dsj_slot_t  slot, prev;
    int fails = 0, checked = 0, data_cnt, extra_left = 0, skip_left = 0;
    int exp_opp = 3, last_opp = 0;
    logic refill;
    logic exp_q[$];  // Demapper's picture of the store, oldest first

    always #20 sys_clk_i = ~sys_clk_i;

    dsj_justifier dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .trib_vld_i(trib_vld_i), .trib_bit_i(trib_bit_i), .slot_i(slot),
        .env_bit_o(env_bit), .env_vld_o(env_vld), .env_dat_o(env_dat),
        .opp_cnt_o(opp_cnt), .ovf_o(ovf), .fill_o(fill));
    dsj_framer_model frm (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .go_i(go), .slot_o(slot), .slot_row_o(srow), .busy_o(busy));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Counts: checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hold reset, then restart the demapper's picture of the store
    task automatic do_reset();
        srst_i <= 1'b1;
        repeat (20) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        exp_q.delete();
        repeat (int'(FILL_CENTER)) exp_q.push_back(1'b0);
        @(posedge sys_clk_i);
    endtask

    // Monitor, demapper and tributary source; refills one bit per data
    // bit read, so the store level only moves by the extra or skipped bits
    always @(posedge sys_clk_i) begin
        prev <= slot;
        prow <= srow;
        refill = 1'b0;
        if (env_vld === 1'b1 && prev.ctl_slot === 1'b1)
            check(16'(env_bit), 16'(prow >= 4'(exp_opp)));
        if (env_vld === 1'b1 && prev.opp_slot === 1'b1)
            check(16'(env_dat), 16'(prow < 4'(exp_opp)));
        // Stuff bits in opportunity slots go out as zero
        if (env_vld === 1'b1 && prev.opp_slot === 1'b1 && env_dat !== 1'b1)
            check(16'(env_bit), 16'h0000);
        if (env_vld === 1'b1 && env_dat === 1'b1) begin
            data_cnt++;
            // Every carried bit must leave in the order it went in
            if (exp_q.size() == 0)
                check(16'(env_bit), 16'hFFFF);
            else
                check(16'(env_bit), 16'(exp_q.pop_front()));
            if (skip_left > 0) skip_left--;
            else refill = 1'b1;
        end
        if (extra_left > 0) begin
            extra_left--;
            refill = 1'b1;
        end
        trib_vld_i <= refill;
        if (refill) begin
            exp_q.push_back(~trib_bit_i);
            trib_bit_i <= ~trib_bit_i;
        end
    end

    // One envelope: preload store, run, then judge its counts
    task automatic run_env(input int extra, input int skip, input int opps,
                           input int bits, input logic [5:0] efill);
        exp_opp = opps;
        extra_left = extra;
        repeat (extra + 3) @(posedge sys_clk_i);
        check(16'(fill), 16'(efill));
        data_cnt = 0;
        skip_left = skip;
        go <= 1'b1;
        @(posedge sys_clk_i);
        go <= 1'b0;
        // The count of the previous envelope is latched at this start
        repeat (3) @(posedge sys_clk_i);
        check(16'(opp_cnt), 16'(last_opp));
        repeat (5647) @(posedge sys_clk_i);
        check(16'(data_cnt), 16'(bits));
        check(16'(ovf), 16'h0000);
        last_opp = opps;
        $display("Envelope done: opps=%0d bits=%0d", opps, data_cnt);
    endtask

    // Overrun: flood the store, then a mid-run reset must clear it
    task automatic run_overrun();
        extra_left = 2 * int'(FILL_CENTER);
        repeat (2 * int'(FILL_CENTER) + 3) @(posedge sys_clk_i);
        check(16'(fill), 16'(FILL_MAX));
        check(16'(ovf), 16'h0001);
        do_reset();
        check(16'(fill), 16'(FILL_CENTER));
        check(16'(ovf), 16'h0000);
        check(16'(opp_cnt), 16'h0000);
        check(16'(env_vld), 16'h0000);
        @(posedge sys_clk_i);
        check(16'(fill), 16'(FILL_CENTER));
        $display("Overrun done: fill=%0h ovf=%0d", fill, ovf);
    endtask

    initial begin
        do_reset();
        run_env(0, 5, 3, 5592, 6'h20);
        run_env(0, 0, 2, 5591, 6'h1B);
        run_env(11, 0, 4, 5593, 6'h26);
        run_env(0, 0, 4, 5593, 6'h26);
        run_overrun();
        print_verdict();
    end

    // Four envelopes and the overrun need about 23000 cycles
    initial begin
        #1200000;
        fails++;
        print_verdict();
    end
endmodule
